// [core/sccg_top.sv]
// Register front end and two synchronism-check stages.
// Assumes a classic Wishbone master and measurements from logic on this clock.
`timescale 1ns/1ns
// Overview of operation
// - Below dead limit a side is dead.
// - Above live limit a side is live.
// - Voltage and frequency-phase criteria, alone or together.
// - Voltage criterion follows selected dead/live pattern.
// - Phase criterion needs both live, differences within.
// - Sync mode closes early by breaker time.
// - Async mode closes once phase within limit.
// - Close command starts a stage request.
// - Request holds until synchronism or timeout.
// - Timeout gives a fixed 200 ms fail.
// - Synchronism gives an internal close command.
// - OK follows synchronism, request or not.
// - Bypass declares synchronism at all times on an enabled stage.
// - Request, OK and fail are outputs.
// - Two stages; second needs extra voltages.
// - Mode is off, async or sync.
// - Pattern letters: reference first, then comparison.
// - Stage one fixed pair; stage two selectable.
module sccg_top #(
	parameter int P_TICK_CYCLES = sccg_pkg::TICK_CYCLES
) (
	// Clock, reset, enable
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// Wishbone slave
	input wire logic i_wb_cyc,
	input wire logic i_wb_stb,
	input wire logic i_wb_we,
	input wire logic [7:0] i_wb_adr,
	input wire logic [3:0] i_wb_sel,
	input wire logic [31:0] i_wb_dat,
	output logic [31:0] o_wb_dat,
	output logic o_wb_ack,
	// Measurements
	input wire logic [15:0] i_u_ref,
	input wire logic [15:0] i_aux_line_line_input_y,
	input wire logic [15:0] i_aux_line_line_input_z,
	input wire logic [1:0][15:0] i_freq_diff,
	input wire logic [1:0][15:0] i_phase_diff,
	input wire logic [1:0][15:0] i_slip_rate,
	// Bypass pins
	input wire logic [1:0] i_bypass,
	// Stage outputs
	output logic [1:0] o_sync_req,
	output logic [1:0] o_sync_ok,
	output logic [1:0] o_sync_fail
);
	localparam int PW = $clog2(P_TICK_CYCLES + 1);

	typedef struct packed {
		logic [31:0] ctrl;
		logic [31:0] ulim;
		logic [31:0] dlim;
		logic [31:0] flim;
		logic [31:0] tmo;
		logic [1:0] cls_seen;
		logic [1:0] fls_seen;
		logic [1:0] start;
		logic ack;
		logic [31:0] dat;
		logic [PW-1:0] pre;
		logic tick;
		logic [1:0] byp_s1;
		logic [1:0] byp_s2;
	} sccg_top_state_type;

	sccg_top_state_type state_reg, state_next;
	sccg_pkg::sccg_cfg_type cfg;
	logic [1:0] stg_req, stg_ok, stg_fail, stg_close;
	logic [1:0][15:0] ref_sel, cmp_sel;
	logic acc;
	logic [31:0] stat_word;

	function automatic logic [31:0] wmerge(input logic [31:0] old, input logic [31:0] d,
		input logic [3:0] sel, input logic [31:0] m);
		logic [31:0] v;
		v = old;
		for (int b = 0; b < 4; b++) begin
			if (sel[b]) begin
				v[8*b +: 8] = d[8*b +: 8];
			end
		end
		return v & m;
	endfunction

	always_comb begin
		cfg.mode = state_reg.ctrl[sccg_pkg::CTRL_MODE_LSB +: 2];
		cfg.pattern = state_reg.ctrl[sccg_pkg::CTRL_PAT_LSB +: 3];
		cfg.dead = state_reg.ulim[15:0];
		cfg.live = state_reg.ulim[sccg_pkg::HI_LSB +: 16];
		cfg.du_lim = state_reg.dlim[15:0];
		cfg.phi_lim = state_reg.dlim[sccg_pkg::HI_LSB +: 16];
		cfg.df_lim = state_reg.flim[15:0];
		cfg.cbt_ms = state_reg.flim[sccg_pkg::HI_LSB +: 10];
		cfg.tmo_ms = state_reg.tmo[19:0];
	end

	// Stage one is wired to a fixed pair, stage two takes the pair setting
	always_comb begin
		ref_sel[0] = i_u_ref;
		cmp_sel[0] = i_aux_line_line_input_y;
		case (state_reg.ctrl[sccg_pkg::CTRL_PAIR_LSB +: 2])
			2'h1: begin
				ref_sel[1] = i_u_ref;
				cmp_sel[1] = i_aux_line_line_input_z;
			end
			2'h2: begin
				ref_sel[1] = i_aux_line_line_input_y;
				cmp_sel[1] = i_aux_line_line_input_z;
			end
			default: begin
				ref_sel[1] = i_u_ref;
				cmp_sel[1] = i_aux_line_line_input_y;
			end
		endcase
	end

	always_comb begin
		stat_word = '0;
		for (int i = 0; i < 2; i++) begin
			stat_word[sccg_pkg::STAT_STRIDE*i + sccg_pkg::STAT_REQ] = stg_req[i];
			stat_word[sccg_pkg::STAT_STRIDE*i + sccg_pkg::STAT_OK] = stg_ok[i];
			stat_word[sccg_pkg::STAT_STRIDE*i + sccg_pkg::STAT_FAIL] = stg_fail[i];
			stat_word[sccg_pkg::STAT_STRIDE*i + sccg_pkg::STAT_CLS] = state_reg.cls_seen[i];
			stat_word[sccg_pkg::STAT_STRIDE*i + sccg_pkg::STAT_FLS] = state_reg.fls_seen[i];
		end
	end

	assign acc = i_wb_cyc && i_wb_stb && !state_reg.ack;

	always_comb begin
		state_next = state_reg;
		state_next.ack = acc;
		state_next.start = 2'h0;
		state_next.byp_s1 = i_bypass;
		state_next.byp_s2 = state_reg.byp_s1;
		// Free-running millisecond tick shared by both stage timers
		if (state_reg.pre == PW'(P_TICK_CYCLES - 1)) begin
			state_next.pre = '0;
			state_next.tick = 1'b1;
		end else begin
			state_next.pre = state_reg.pre + PW'(1);
			state_next.tick = 1'b0;
		end
		if (acc && i_wb_we) begin
			case (i_wb_adr)
				sccg_pkg::OFS_CTRL: state_next.ctrl = wmerge(state_reg.ctrl, i_wb_dat, i_wb_sel, sccg_pkg::CTRL_MASK);
				sccg_pkg::OFS_ULIM: state_next.ulim = wmerge(state_reg.ulim, i_wb_dat, i_wb_sel, sccg_pkg::ULIM_MASK);
				sccg_pkg::OFS_DLIM: state_next.dlim = wmerge(state_reg.dlim, i_wb_dat, i_wb_sel, sccg_pkg::DLIM_MASK);
				sccg_pkg::OFS_FLIM: state_next.flim = wmerge(state_reg.flim, i_wb_dat, i_wb_sel, sccg_pkg::FLIM_MASK);
				sccg_pkg::OFS_TMO: state_next.tmo = wmerge(state_reg.tmo, i_wb_dat, i_wb_sel, sccg_pkg::TMO_MASK);
				sccg_pkg::OFS_CMD: begin
					if (i_wb_sel[0]) begin
						state_next.start = i_wb_dat[1:0];
					end
				end
				sccg_pkg::OFS_STAT: begin
					for (int i = 0; i < 2; i++) begin
						if (i_wb_sel[i] && i_wb_dat[sccg_pkg::STAT_STRIDE*i + sccg_pkg::STAT_CLS]) begin
							state_next.cls_seen[i] = 1'b0;
						end
						if (i_wb_sel[i] && i_wb_dat[sccg_pkg::STAT_STRIDE*i + sccg_pkg::STAT_FLS]) begin
							state_next.fls_seen[i] = 1'b0;
						end
					end
				end
				default: begin
				end
			endcase
		end
		// A stage event in the clearing cycle still sets its flag
		state_next.cls_seen = state_next.cls_seen | stg_close;
		state_next.fls_seen = state_next.fls_seen | (stg_fail & ~stg_req);
		if (acc && !i_wb_we) begin
			case (i_wb_adr)
				sccg_pkg::OFS_CTRL: state_next.dat = state_reg.ctrl;
				sccg_pkg::OFS_ULIM: state_next.dat = state_reg.ulim;
				sccg_pkg::OFS_DLIM: state_next.dat = state_reg.dlim;
				sccg_pkg::OFS_FLIM: state_next.dat = state_reg.flim;
				sccg_pkg::OFS_TMO: state_next.dat = state_reg.tmo;
				sccg_pkg::OFS_STAT: state_next.dat = stat_word;
				default: state_next.dat = '0;
			endcase
		end
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= '0;
			state_reg.ctrl <= sccg_pkg::CTRL_RST;
			state_reg.ulim <= sccg_pkg::ULIM_RST;
			state_reg.dlim <= sccg_pkg::DLIM_RST;
			state_reg.flim <= sccg_pkg::FLIM_RST;
			state_reg.tmo <= sccg_pkg::TMO_RST;
		end else if (i_ce) begin
			state_reg <= state_next;
		end
	end

	for (genvar g = 0; g < 2; g++) begin : g_stage
		sccg_stage_if sif();
		assign sif.ce = i_ce;
		assign sif.tick = state_reg.tick;
		assign sif.start = state_reg.start[g];
		// Stage two only starts a request or declares synchronism while the stage two enable bit of the control register is set
		assign sif.en = (g == 0) ? 1'b1 : state_reg.ctrl[sccg_pkg::CTRL_EN2_BIT];
		assign sif.bypass = state_reg.byp_s2[g] || state_reg.ctrl[sccg_pkg::CTRL_BYP_BIT];
		assign sif.ref_u = ref_sel[g];
		assign sif.cmp_u = cmp_sel[g];
		assign sif.df = i_freq_diff[g];
		assign sif.dphi = i_phase_diff[g];
		assign sif.slip = i_slip_rate[g];
		assign sif.cfg = cfg;
		assign stg_req[g] = sif.req;
		assign stg_ok[g] = sif.ok;
		assign stg_fail[g] = sif.fail;
		assign stg_close[g] = sif.close;
		sccg_stage u_stage (
			.i_sys_clk(i_sys_clk),
			.i_rst_n(i_rst_n),
			.s(sif)
		);
	end

	assign o_wb_dat = state_reg.dat;
	assign o_wb_ack = state_reg.ack;
	assign o_sync_req = stg_req;
	assign o_sync_ok = stg_ok;
	assign o_sync_fail = stg_fail;

	a_ack_single: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && acc |=> o_wb_ack ##1 (!o_wb_ack || !$past(i_ce)))
		else $error("ack not a single cycle answer");
	a_close_sticky: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && stg_close[0] |=> state_reg.cls_seen[0])
		else $error("close event not recorded");
	a_start_cmd: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
		i_ce && acc && i_wb_we && i_wb_adr == sccg_pkg::OFS_CMD && i_wb_sel[0] && i_wb_dat[0]
		|=> state_reg.start[0])
		else $error("close command not passed to stage");

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	// A close command taken while stage one is idle
	sequence s_cmd_one;
		i_ce && acc && i_wb_we && i_wb_adr == sccg_pkg::OFS_CMD && i_wb_sel[0] && i_wb_dat[0]
			&& !o_sync_req[0] && !o_sync_fail[0];
	endsequence

	a_cmd_raises_req: assert property (
		s_cmd_one ##1 i_ce
		|=> o_sync_req[0])
		else $error("close command raised no request");

	a_start_clears: assert property (
		i_ce && !(acc && i_wb_we && i_wb_adr == sccg_pkg::OFS_CMD)
		|=> state_reg.start == 2'h0)
		else $error("start pulse longer than one cycle");

	a_stage_one_pair: assert property (
		ref_sel[0] == i_u_ref && cmp_sel[0] == i_aux_line_line_input_y)
		else $error("stage one pair not fixed");

	a_pair_ref_z: assert property (
		state_reg.ctrl[sccg_pkg::CTRL_PAIR_LSB +: 2] == 2'h1
		|-> ref_sel[1] == i_u_ref && cmp_sel[1] == i_aux_line_line_input_z)
		else $error("stage two pair ref/z wrong");

	a_pair_y_z: assert property (
		state_reg.ctrl[sccg_pkg::CTRL_PAIR_LSB +: 2] == 2'h2
		|-> ref_sel[1] == i_aux_line_line_input_y && cmp_sel[1] == i_aux_line_line_input_z)
		else $error("stage two pair y/z wrong");

	a_byp_first_flop: assert property (
		i_ce
		|=> state_reg.byp_s1 == $past(i_bypass))
		else $error("bypass pin not sampled");

	a_byp_second_flop: assert property (
		i_ce
		|=> state_reg.byp_s2 == $past(state_reg.byp_s1))
		else $error("bypass second flop skipped");

	a_soft_bypass_ok: assert property (
		i_ce && state_reg.ctrl[sccg_pkg::CTRL_BYP_BIT]
		|=> o_sync_ok[0])
		else $error("soft bypass gave no ok");

	a_stage_two_ok_off: assert property (
		i_ce && !state_reg.ctrl[sccg_pkg::CTRL_EN2_BIT]
		|=> !o_sync_ok[1])
		else $error("disabled stage two reports ok");

	a_stage_two_idle: assert property (
		i_ce && !state_reg.ctrl[sccg_pkg::CTRL_EN2_BIT] && !o_sync_req[1]
		|=> !o_sync_req[1])
		else $error("disabled stage two raised request");

	a_fail_seen_set: assert property (
		i_ce && stg_fail[0] && !stg_req[0]
		|=> state_reg.fls_seen[0])
		else $error("fail event not recorded");

	a_close_seen_two: assert property (
		i_ce && stg_close[1]
		|=> state_reg.cls_seen[1])
		else $error("stage two close not recorded");

	a_close_seen_clear: assert property (
		i_ce && acc && i_wb_we && i_wb_adr == sccg_pkg::OFS_STAT && i_wb_sel[0]
		&& i_wb_dat[sccg_pkg::STAT_CLS] && !stg_close[0]
		|=> !state_reg.cls_seen[0])
		else $error("close flag not cleared");

	a_close_seen_hold: assert property (
		i_ce && state_reg.cls_seen[0] && !(acc && i_wb_we)
		|=> state_reg.cls_seen[0])
		else $error("close flag lost");

	a_stat_read: assert property (
		i_ce && acc && !i_wb_we && i_wb_adr == sccg_pkg::OFS_STAT
		|=> o_wb_dat[sccg_pkg::STAT_REQ] == $past(o_sync_req[0])
		&& o_wb_dat[sccg_pkg::STAT_FAIL] == $past(o_sync_fail[0]))
		else $error("status read disagrees with outputs");

	a_ce_freeze: assert property (
		!i_ce
		|=> $stable(state_reg))
		else $error("state moved with enable low");

	a_cmd_reads_zero: assert property (
		i_ce && acc && !i_wb_we && i_wb_adr == sccg_pkg::OFS_CMD
		|=> o_wb_dat == 32'h0000_0000)
		else $error("command register read not zero");

	a_ctrl_masked: assert property (
		i_ce && acc && i_wb_we && i_wb_adr == sccg_pkg::OFS_CTRL
		|=> (state_reg.ctrl & ~sccg_pkg::CTRL_MASK) == 32'h0000_0000)
		else $error("reserved control bits stored");

	a_ack_needs_req: assert property (
		i_ce && !acc
		|=> !o_wb_ack)
		else $error("ack without request");
endmodule

// [core/sccg_pkg.sv]
// Shared constants and types of the synchronism-check close gate.
// Assumes a 100 MHz system clock and a 32-bit classic Wishbone slave.
package sccg_pkg;
	localparam int CLK_PERIOD_NS = 10;
	localparam int TICK_NS = 1000000;
	localparam int TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
	localparam int FAIL_PULSE_MS = 200;
	// Stage timers count 1 ms ticks
	localparam logic [19:0] FAIL_TICKS = 20'(FAIL_PULSE_MS * 1000000 / TICK_NS);

	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_ULIM = 8'h04;
	localparam logic [7:0] OFS_DLIM = 8'h08;
	localparam logic [7:0] OFS_FLIM = 8'h0C;
	localparam logic [7:0] OFS_TMO = 8'h10;
	localparam logic [7:0] OFS_CMD = 8'h14;
	localparam logic [7:0] OFS_STAT = 8'h18;

	localparam int CTRL_MODE_LSB = 0;
	localparam int CTRL_PAT_LSB = 2;
	localparam int CTRL_BYP_BIT = 5;
	localparam int CTRL_EN2_BIT = 6;
	localparam int CTRL_PAIR_LSB = 7;
	localparam int HI_LSB = 16;
	localparam int STAT_REQ = 0;
	localparam int STAT_OK = 1;
	localparam int STAT_FAIL = 2;
	localparam int STAT_CLS = 3;
	localparam int STAT_FLS = 4;
	localparam int STAT_STRIDE = 8;
	localparam int PAT_DD = 0;
	localparam int PAT_DL = 1;
	localparam int PAT_LD = 2;

	localparam logic [31:0] CTRL_MASK = 32'h0000_01FF;
	localparam logic [31:0] ULIM_MASK = 32'hFFFF_FFFF;
	localparam logic [31:0] DLIM_MASK = 32'hFFFF_FFFF;
	localparam logic [31:0] FLIM_MASK = 32'h03FF_FFFF;
	localparam logic [31:0] TMO_MASK = 32'h000F_FFFF;

	localparam logic [31:0] CTRL_RST = 32'h0000_0000;
	localparam logic [31:0] ULIM_RST = 32'h00F0_0010;
	localparam logic [31:0] DLIM_RST = 32'h0200_0020;
	localparam logic [31:0] FLIM_RST = 32'h0064_0010;
	localparam logic [31:0] TMO_RST = 32'h0000_2710;

	typedef enum logic [1:0] {
		SCCG_MODE_OFF = 2'b00,
		SCCG_MODE_ASYNC = 2'b01,
		SCCG_MODE_SYNC = 2'b10
	} sccg_mode_type;

	typedef struct packed {
		logic [1:0] mode;
		logic [2:0] pattern;
		logic [15:0] dead;
		logic [15:0] live;
		logic [15:0] du_lim;
		logic [15:0] phi_lim;
		logic [15:0] df_lim;
		logic [9:0] cbt_ms;
		logic [19:0] tmo_ms;
	} sccg_cfg_type;
endpackage

// [core/sccg_stage_if.sv]
// Carrier between the register front end and one check stage.
// Assumes both ends run on the system clock.
`timescale 1ns/1ns
interface sccg_stage_if;
	logic ce;
	logic tick;
	logic start;
	logic en;
	logic bypass;
	logic [15:0] ref_u;
	logic [15:0] cmp_u;
	logic [15:0] df;
	logic [15:0] dphi;
	logic [15:0] slip;
	sccg_pkg::sccg_cfg_type cfg;
	logic req;
	logic ok;
	logic fail;
	logic close;
	modport ctl(output ce, tick, start, en, bypass, ref_u, cmp_u, df, dphi, slip, cfg,
		input req, ok, fail, close);
	modport stg(input ce, tick, start, en, bypass, ref_u, cmp_u, df, dphi, slip, cfg,
		output req, ok, fail, close);
endinterface

// [core/sccg_stage.sv]
// One synchronism-check stage: criteria, request timer and fail pulse.
// Assumes a 1 ms tick pulse and settings on the system clock.
`timescale 1ns/1ns
module sccg_stage (
	// Clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rst_n,
	// Stage carrier
	sccg_stage_if.stg s
);
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_REQ = 2'b01,
		ST_FAIL = 2'b10
	} sccg_st_type;

	typedef struct packed {
		sccg_st_type st;
		logic [19:0] cnt;
		logic req;
		logic ok;
		logic fail;
		logic close;
	} sccg_stg_state_type;

	sccg_stg_state_type state_reg, state_next;
	logic ref_dead, ref_live, cmp_dead, cmp_live;
	logic volt_ok, freq_ok, ang_ok, sync_ok;
	logic [15:0] du;
	logic [25:0] adv;

	always_comb begin
		ref_dead = s.ref_u < s.cfg.dead;
		cmp_dead = s.cmp_u < s.cfg.dead;
		ref_live = s.ref_u > s.cfg.live;
		cmp_live = s.cmp_u > s.cfg.live;
		// First letter is the reference side, second the compared side
		volt_ok = (s.cfg.pattern[sccg_pkg::PAT_DD] && ref_dead && cmp_dead)
			|| (s.cfg.pattern[sccg_pkg::PAT_DL] && ref_dead && cmp_live)
			|| (s.cfg.pattern[sccg_pkg::PAT_LD] && ref_live && cmp_dead);
		du = (s.ref_u > s.cmp_u) ? s.ref_u - s.cmp_u : s.cmp_u - s.ref_u;
		// Phase advance over the breaker closing time
		adv = 26'(s.slip) * 26'(s.cfg.cbt_ms);
		if (s.cfg.mode == sccg_pkg::SCCG_MODE_SYNC) begin
			ang_ok = ({10'h000, s.dphi} <= adv) && (s.dphi <= s.cfg.phi_lim);
		end else begin
			ang_ok = s.dphi <= s.cfg.phi_lim;
		end
		freq_ok = ((s.cfg.mode == sccg_pkg::SCCG_MODE_ASYNC) || (s.cfg.mode == sccg_pkg::SCCG_MODE_SYNC))
			&& ref_live && cmp_live && (du <= s.cfg.du_lim) && (s.df <= s.cfg.df_lim) && ang_ok;
		// Either enabled criterion is enough on its own
		sync_ok = s.en && (s.bypass || volt_ok || freq_ok);
	end

	always_comb begin
		state_next = state_reg;
		state_next.close = 1'b0;
		state_next.ok = sync_ok;
		case (state_reg.st)
			ST_IDLE: begin
				if (s.start && s.en) begin
					state_next.st = ST_REQ;
					state_next.req = 1'b1;
					state_next.cnt = '0;
				end
			end
			ST_REQ: begin
				// Repeated starts are not looked at here, so the timer runs on
				if (sync_ok) begin
					state_next.st = ST_IDLE;
					state_next.req = 1'b0;
					state_next.close = 1'b1;
				end else if (s.tick) begin
					if (state_reg.cnt >= s.cfg.tmo_ms) begin
						state_next.st = ST_FAIL;
						state_next.req = 1'b0;
						state_next.fail = 1'b1;
						state_next.cnt = '0;
					end else begin
						state_next.cnt = state_reg.cnt + 20'h00001;
					end
				end
			end
			ST_FAIL: begin
				if (s.tick) begin
					if (state_reg.cnt == sccg_pkg::FAIL_TICKS - 20'h00001) begin
						state_next.st = ST_IDLE;
						state_next.fail = 1'b0;
					end else begin
						state_next.cnt = state_reg.cnt + 20'h00001;
					end
				end
			end
			default: begin
				state_next = '0;
			end
		endcase
	end

	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			state_reg <= '0;
		end else if (s.ce) begin
			state_reg <= state_next;
		end
	end

	assign s.req = state_reg.req;
	assign s.ok = state_reg.ok;
	assign s.fail = state_reg.fail;
	assign s.close = state_reg.close;

	default clocking @(posedge i_sys_clk); endclocking
	default disable iff (!i_rst_n);

	sequence s_start_taken;
		s.ce && state_reg.st == ST_IDLE && s.start && s.en;
	endsequence
	sequence s_req_met;
		s.ce && state_reg.req && sync_ok;
	endsequence
	sequence s_req_expired;
		s.ce && state_reg.req && !sync_ok && s.tick && state_reg.cnt >= s.cfg.tmo_ms;
	endsequence

	a_start_raises_req: assert property (s_start_taken |=> state_reg.req && !state_reg.close)
		else $error("request not raised at start");
	a_close_on_sync: assert property (s_req_met |=> state_reg.close && !state_reg.req && !state_reg.fail)
		else $error("no close on synchronism");
	a_fail_on_timeout: assert property (s_req_expired |=> state_reg.fail && !state_reg.close ##1 state_reg.fail)
		else $error("no fail at timeout");
	a_one_outcome: assert property (!(state_reg.close && (state_reg.fail || state_reg.req)))
		else $error("close together with fail or request");
	a_fail_length: assert property ($fell(state_reg.fail) |-> $past(state_reg.cnt) == sccg_pkg::FAIL_TICKS - 20'h00001)
		else $error("fail pulse length wrong");
	a_restart_ignored: assert property (s.ce && state_reg.req && s.start && !sync_ok && !s.tick
		|=> state_reg.req && state_reg.cnt == $past(state_reg.cnt))
		else $error("repeated start disturbed request");
	a_ok_tracks: assert property (s.ce |=> state_reg.ok == $past(sync_ok))
		else $error("ok does not follow synchronism");
	a_bypass_ok: assert property (s.ce && s.en && s.bypass ##1 s.ce && s.en && s.bypass |=> state_reg.ok [*1])
		else $error("bypass did not declare synchronism");
	a_dead_dead: assert property (s.ce && s.en && s.cfg.pattern[sccg_pkg::PAT_DD]
		&& s.ref_u < s.cfg.dead && s.cmp_u < s.cfg.dead |=> state_reg.ok)
		else $error("dead-dead pattern not declared");
	a_mode_off: assert property (s.ce && s.cfg.mode == sccg_pkg::SCCG_MODE_OFF && s.cfg.pattern == 3'h0
		&& !s.bypass |=> !state_reg.ok)
		else $error("frequency criterion used while off");
endmodule

// [testbench/sccg_obj_ctl.sv]
// Object control model: a Wishbone master that sets up the gate and sends close commands.
// Assumes a classic Wishbone slave on the same clock.
`timescale 1ns/1ns
module sccg_obj_ctl (
	// Clock
	input wire logic i_sys_clk,
	// Wishbone master
	input wire logic i_wb_ack,
	input wire logic [31:0] i_wb_dat,
	output logic o_wb_cyc,
	output logic o_wb_stb,
	output logic o_wb_we,
	output logic [7:0] o_wb_adr,
	output logic [3:0] o_wb_sel,
	output logic [31:0] o_wb_dat
);
	initial begin
		o_wb_cyc = 1'b0;
		o_wb_stb = 1'b0;
		o_wb_we = 1'b0;
		o_wb_adr = 8'h00;
		o_wb_sel = 4'h0;
		o_wb_dat = 32'h0;
	end

	// Released address, select and data lines carry the inverse so stale values never look valid
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r);
		@(posedge i_sys_clk);
		o_wb_cyc <= 1'b1;
		o_wb_stb <= 1'b1;
		o_wb_we <= w;
		o_wb_adr <= a;
		o_wb_sel <= s;
		o_wb_dat <= d;
		do @(posedge i_sys_clk); while (i_wb_ack !== 1'b1);
		r = i_wb_dat;
		o_wb_cyc <= 1'b0;
		o_wb_stb <= 1'b0;
		o_wb_we <= 1'b0;
		o_wb_adr <= ~a;
		o_wb_sel <= ~s;
		o_wb_dat <= ~d;
	endtask

	task automatic close_cmd(input int g);
		logic [31:0] r;
		xfer(1'b1, sccg_pkg::OFS_CMD, 32'h1 << g, 4'h1, r);
	endtask
endmodule

// [testbench/tb_sccg_top.sv]
// Self-checking bench of the synchronism-check gate.
// Assumes a 1 ms tick shortened to 10 cycles; read data is checked from a queue of expectations.
`timescale 1ns/1ns
module tb_sccg_top;
	localparam int TB_TICK = 10;
	logic i_sys_clk, i_rst_n, i_ce, cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic [15:0] u_ref, u_y, u_z;
	logic [1:0][15:0] fdiff, pdiff, slip;
	logic [1:0] byp, req, ok, fail;
	logic [31:0] exp_q[$];
	int tests_run, bad_count, dt;
	time t0;
	logic rd_dead, cmp_dead, hit;
	logic [7:0] ofs[8] = '{sccg_pkg::OFS_CTRL, sccg_pkg::OFS_ULIM, sccg_pkg::OFS_DLIM, sccg_pkg::OFS_FLIM,
		sccg_pkg::OFS_TMO, sccg_pkg::OFS_CMD, sccg_pkg::OFS_STAT, 8'h40};
	logic [31:0] rv[8] = '{sccg_pkg::CTRL_RST, sccg_pkg::ULIM_RST, sccg_pkg::DLIM_RST, sccg_pkg::FLIM_RST,
		sccg_pkg::TMO_RST, 32'h0, 32'h0, 32'h0};

	sccg_top #(.P_TICK_CYCLES(TB_TICK)) u_sccg_top (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ce(i_ce),
		.i_wb_cyc(cyc), .i_wb_stb(stb), .i_wb_we(we), .i_wb_adr(adr), .i_wb_sel(sel), .i_wb_dat(wdat),
		.o_wb_dat(rdat), .o_wb_ack(ack), .i_u_ref(u_ref), .i_aux_line_line_input_y(u_y),
		.i_aux_line_line_input_z(u_z), .i_freq_diff(fdiff), .i_phase_diff(pdiff), .i_slip_rate(slip),
		.i_bypass(byp), .o_sync_req(req), .o_sync_ok(ok), .o_sync_fail(fail));
	sccg_obj_ctl u_sccg_obj_ctl (.i_sys_clk(i_sys_clk), .i_wb_ack(ack), .i_wb_dat(rdat), .o_wb_cyc(cyc),
		.o_wb_stb(stb), .o_wb_we(we), .o_wb_adr(adr), .o_wb_sel(sel), .o_wb_dat(wdat));

	initial begin
		i_sys_clk = 1'b0;
		forever #5 i_sys_clk = ~i_sys_clk;
	end

	task automatic test_done();
		$display("checks %0d mismatches %0d", tests_run, bad_count);
		if (bad_count == 0 && tests_run > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			bad_count++;
			$display("unexpected %s: expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step(input int n);
		repeat (n) @(posedge i_sys_clk);
		#1;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [31:0] r;
		u_sccg_obj_ctl.xfer(1'b1, a, d, s, r);
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] r;
		exp_q.push_back(e);
		u_sccg_obj_ctl.xfer(1'b0, a, 32'h0, 4'hF, r);
	endtask

	// Read data is judged at the ack edge against the oldest note
	always @(posedge i_sys_clk) begin
		if (ack === 1'b1 && cyc === 1'b1 && we === 1'b0)
			chk("read data", rdat, exp_q.pop_front());
	end

	function automatic logic [15:0] lv();
		return 16'($urandom_range(16'hFFFF, 16'h00F1));
	endfunction

	function automatic logic [15:0] dv();
		return 16'($urandom_range(15, 0));
	endfunction

	task automatic ok_case(input logic [31:0] c, input logic [15:0] ur, uy, uz, df, ph, input logic [1:0] b,
		input logic [1:0] e);
		wr(sccg_pkg::OFS_CTRL, c, 4'hF);
		@(posedge i_sys_clk);
		u_ref <= ur;
		u_y <= uy;
		u_z <= uz;
		fdiff <= {df, df};
		pdiff <= {ph, ph};
		slip <= {16'h0001, 16'h0001};
		byp <= b;
		step(5);
		chk("sync ok", {30'h0, ok}, {30'h0, e});
	endtask

	task automatic wait_bit(input int k, input logic v, input int maxc);
		int n;
		n = 0;
		while (((k == 0) ? req[0] : fail[0]) !== v && n < maxc) begin
			step(1);
			n++;
		end
	endtask

	initial begin
		repeat (20000) @(posedge i_sys_clk);
		bad_count++;
		test_done();
	end

	initial begin
		i_rst_n = 1'b0;
		i_ce = 1'b1;
		{u_ref, u_y, u_z, fdiff, pdiff, slip, byp} = '0;
		void'($urandom(84));
		repeat (5) @(posedge i_sys_clk);
		i_rst_n <= 1'b1;
		for (int i = 0; i < 8; i++)
			rd(ofs[i], rv[i]);
		wr(sccg_pkg::OFS_CTRL, 32'hFFFF_FFFF, 4'hF);
		rd(sccg_pkg::OFS_CTRL, sccg_pkg::CTRL_MASK);
		wr(sccg_pkg::OFS_ULIM, 32'h1234_5678, 4'h1);
		rd(sccg_pkg::OFS_ULIM, 32'h00F0_0078);
		wr(sccg_pkg::OFS_ULIM, sccg_pkg::ULIM_RST, 4'hF);
		wr(8'h40, 32'hFFFF_FFFF, 4'hF);
		rd(8'h40, 32'h0);
		// Each pattern against every dead/live combination of the two sides
		for (int p = 0; p < 3; p++) begin
			for (int c = 0; c < 4; c++) begin
				rd_dead = c[1];
				cmp_dead = c[0];
				hit = (p == 0) ? (rd_dead && cmp_dead) : (p == 1) ? (rd_dead && !cmp_dead) : (!rd_dead && cmp_dead);
				ok_case(32'h1 << (2 + p), rd_dead ? dv() : lv(), cmp_dead ? dv() : lv(), lv(), 0, 0, 0, {1'b0, hit});
			end
		end
		ok_case(32'h04, 16'h0010, 16'h0000, 16'h0, 0, 0, 0, 2'b00);
		ok_case(32'h08, 16'h0000, 16'h00F0, 16'h0, 0, 0, 0, 2'b00);
		ok_case(32'h1, 16'h0400, 16'h0410, 16'h0, 16'h0008, 16'h0150, 0, 2'b01);
		ok_case(32'h2, 16'h0400, 16'h0410, 16'h0, 16'h0008, 16'h0150, 0, 2'b00);
		ok_case(32'h2, 16'h0400, 16'h0410, 16'h0, 16'h0008, 16'h0030, 0, 2'b01);
		ok_case(32'h0, 16'h0400, 16'h0410, 16'h0, 16'h0008, 16'h0030, 0, 2'b00);
		ok_case(32'h3, 16'h0400, 16'h0410, 16'h0, 16'h0008, 16'h0030, 0, 2'b00);
		ok_case(32'h1, 16'h0400, 16'h0410, 16'h0, 16'h0011, 16'h0030, 0, 2'b00);
		ok_case(32'h1, 16'h0400, 16'h0421, 16'h0, 16'h0008, 16'h0030, 0, 2'b00);
		ok_case(32'h1, 16'h0008, 16'h0008, 16'h0, 16'h0008, 16'h0030, 0, 2'b00);
		ok_case(32'h148, lv(), dv(), lv(), 0, 0, 0, 2'b10);
		ok_case(32'h008, lv(), dv(), lv(), 0, 0, 0, 2'b00);
		ok_case(32'h0C8, dv(), dv(), lv(), 0, 0, 0, 2'b10);
		ok_case(32'h0, lv(), lv(), lv(), 0, 0, 2'b01, 2'b01);
		ok_case(32'h60, lv(), lv(), lv(), 0, 0, 0, 2'b11);
		// Request ended by synchronism
		ok_case(32'h0, 16'h0400, 16'h0410, 16'h0, 0, 0, 0, 2'b00);
		u_sccg_obj_ctl.close_cmd(0);
		wait_bit(0, 1'b1, 4);
		chk("request", {31'h0, req[0]}, 32'h1);
		ok_case(32'h08, dv(), lv(), 16'h0, 0, 0, 0, 2'b01);
		chk("request", {30'h0, req}, 32'h0);
		chk("fail", {30'h0, fail}, 32'h0);
		u_sccg_obj_ctl.close_cmd(1);
		step(3);
		chk("request", {30'h0, req}, 32'h0);
		rd(sccg_pkg::OFS_STAT, 32'h0000_000A);
		wr(sccg_pkg::OFS_STAT, 32'h18, 4'h1);
		// Request ended by timeout, with commands during request and fail
		ok_case(32'h0, 16'h0400, 16'h0410, 16'h0, 0, 0, 0, 2'b00);
		wr(sccg_pkg::OFS_TMO, 32'h3, 4'hF);
		u_sccg_obj_ctl.close_cmd(0);
		wait_bit(0, 1'b1, 4);
		t0 = $time;
		step(15);
		u_sccg_obj_ctl.close_cmd(0);
		wait_bit(0, 1'b0, 100);
		dt = int'(($time - t0) / 10);
		chk("timeout span", 32'((dt >= 3 * TB_TICK - 1) && (dt <= 4 * TB_TICK + 1)), 32'h1);
		chk("fail", {31'h0, fail[0]}, 32'h1);
		t0 = $time;
		// Enable low for 50 edges stretches the pulse by exactly that much
		@(posedge i_sys_clk);
		i_ce <= 1'b0;
		repeat (50) @(posedge i_sys_clk);
		i_ce <= 1'b1;
		u_sccg_obj_ctl.close_cmd(0);
		wait_bit(1, 1'b0, 3000);
		chk("fail length", 32'(($time - t0) / 10), 32'(sccg_pkg::FAIL_PULSE_MS * TB_TICK + 50));
		chk("request", {30'h0, req}, 32'h0);
		rd(sccg_pkg::OFS_STAT, 32'h0000_0010);
		step(2);
		test_done();
	end
endmodule
